/* File: apsc_pkg.sv */
// Constants and shared types of the automatic power state control block
package apsc_pkg;

    // ==================================================================
    // Register map (byte addresses)
    localparam logic [7:0]  ADDR_CTRL_ONE   = 8'h04;
    localparam logic [7:0]  ADDR_SNZ_PERIOD = 8'h0C;
    localparam logic [7:0]  ADDR_WAKE_CFG   = 8'h10;
    localparam logic [7:0]  ADDR_STATUS     = 8'h14;

    // ==================================================================
    // Power sequencing control register one
    localparam logic [31:0] CTRL_ONE_RESET  = 32'h8102_0738;
    localparam logic [31:0] CTRL_ONE_WMASK  = 32'hFC02_FFFA;
    localparam int          RX_INIT_BIT     = 1;
    localparam int          RFSEQ_LSB       = 3;
    localparam int          RFSEQ_MSB       = 10;
    localparam int          TX_SLP_BIT      = 11;
    localparam int          RX_SLP_BIT      = 12;
    localparam int          SNZ_EN_BIT      = 13;
    localparam int          SNZ_RPT_BIT     = 14;
    localparam int          EDGE_RUN_BIT    = 17;
    localparam int          KHZ_LSB         = 26;
    localparam int          KHZ_MSB         = 31;
    localparam logic [7:0]  RFSEQ_HANDOVER  = 8'hE7;

    // ==================================================================
    // Snooze period, wake configuration and status
    localparam logic [7:0]  SNZ_PERIOD_RESET = 8'h00;
    localparam logic [2:0]  WAKE_CFG_RESET   = 3'h0;
    localparam int          SLEEP_EN_BIT     = 0;
    localparam int          PRESERVE_SLEEP_CONFIG_BIT   = 1;
    localparam int          DEEP_SEL_BIT     = 2;
    localparam int          STAT_IRQ_BIT     = 4;
    localparam int          STAT_KHZ_BIT     = 5;
    localparam int          STAT_SNZ_BIT     = 6;

    // ==================================================================
    // Bus responses
    localparam logic [1:0]  RESP_OKAY   = 2'h0;
    localparam logic [1:0]  RESP_SLVERR = 2'h2;

    // ==================================================================
    // Timing: system clock and crystal-derived clock in hertz
    localparam logic [26:0] CLK_HZ      = 27'd40_000_000;
    localparam logic [26:0] XTAL_HZ     = 27'd19_200_000;
    localparam logic [3:0]  KHZ_LOW_PAD = 4'h0;
    localparam int          SNZ_UNIT_TICKS = 256;

    // ==================================================================
    // Types
    typedef enum logic [1:0] {
        PS_ACTIVE,
        PS_INIT,
        PS_SLEEP,
        PS_SNOOZE
    } apsc_pstate_t;

    typedef struct packed {
        logic tx_done;
        logic rx_end;
        logic wake;
        logic irq_pending;
    } apsc_evt_t;

    typedef struct packed {
        apsc_pstate_t pstate;
        logic         deep_sleep;
        logic         rf_seq_en;
        logic [7:0]   rf_seq_mask;
        logic         edge_run_en;
        logic         rx_start;
    } apsc_ctl_t;

    typedef struct packed {
        logic [26:0] acc;
        logic        xtick;
        logic [9:0]  cnt;
        logic        khz_clk;
        logic        khz_tick;
    } apsc_div_st_t;

    typedef struct packed {
        logic        busy;
        logic [23:0] cnt;
        logic        done;
    } apsc_snz_st_t;

    typedef struct packed {
        logic         aw_have;
        logic [7:0]   aw_addr;
        logic         w_have;
        logic [31:0]  w_data;
        logic [3:0]   w_strb;
        logic         bvalid;
        logic [1:0]   bresp;
        logic         rvalid;
        logic [31:0]  rdata;
        logic [1:0]   rresp;
        logic [31:0]  ctrl;
        logic [7:0]   snz_per;
        logic [2:0]   wcfg;
        apsc_pstate_t pstate;
        logic         rx_start;
        logic         snz_start;
    } apsc_top_st_t;

endpackage : apsc_pkg

/* File: apsc_xtal_div.sv */
// Crystal-rate tick and kilohertz clock divider
`timescale 1ns/1ps
module apsc_xtal_div (
    // Clock and reset
    input  wire logic       aclk,
    input  wire logic       aresetn,
    // Divider setting, upper six bits of the ten-bit count
    input  wire logic [5:0] div_hi,
    // Outputs
    output logic            xtal_tick,
    output logic            khz_clk,
    output logic            khz_tick
);
    apsc_pkg::apsc_div_st_t q;
    apsc_pkg::apsc_div_st_t d;
    logic [26:0]            sum;
    logic [9:0]             half;

    always_comb begin
        d          = q;
        d.xtick    = 1'b0;
        d.khz_tick = 1'b0;
        // Fractional accumulator gives 19.2 MHz ticks from 40 MHz
        sum        = q.acc + apsc_pkg::XTAL_HZ;
        if (sum >= apsc_pkg::CLK_HZ) begin
            d.acc   = sum - apsc_pkg::CLK_HZ;
            d.xtick = 1'b1;
        end else begin
            d.acc   = sum;
        end
        half = {div_hi, apsc_pkg::KHZ_LOW_PAD};
        if (div_hi == 6'h00) begin
            d.cnt = 10'h000;
        end else if (q.xtick) begin
            if (q.cnt >= half - 10'h001) begin // R15
                d.cnt      = 10'h000;
                d.khz_clk  = ~q.khz_clk;
                d.khz_tick = ~q.khz_clk;
            end else begin
                d.cnt = q.cnt + 10'h001;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign xtal_tick = q.xtick;
    assign khz_clk   = q.khz_clk;
    assign khz_tick  = q.khz_tick;

endmodule : apsc_xtal_div

/* File: apsc_snooze_tmr.sv */
// Snooze period timer counted in crystal-rate ticks
`timescale 1ns/1ps
module apsc_snooze_tmr #(
    parameter int UNIT_TICKS = apsc_pkg::SNZ_UNIT_TICKS
) (
    // Clock and reset
    input  wire logic       aclk,
    input  wire logic       aresetn,
    // Control
    input  wire logic       start,
    input  wire logic [7:0] period,
    input  wire logic       tick,
    // Status
    output logic            busy,
    output logic            done
);
    localparam logic [15:0] UNIT = 16'(UNIT_TICKS);

    apsc_pkg::apsc_snz_st_t q;
    apsc_pkg::apsc_snz_st_t d;

    always_comb begin
        d      = q;
        d.done = 1'b0;
        if (start) begin
            d.busy = 1'b1;
            d.cnt  = 24'(period * UNIT); // R12
        end else if (q.busy && tick) begin
            if (q.cnt <= 24'h000001) begin
                d.busy = 1'b0;
                d.cnt  = 24'h000000;
                d.done = 1'b1;
            end else begin
                d.cnt  = q.cnt - 24'h000001;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign busy = q.busy;
    assign done = q.done;

endmodule : apsc_snooze_tmr

/* File: apsc_top.sv */
// Automatic power state control with its register slave
// Notes on behaviour
// R1 - Thirty-two bit control register at offset 0x04
// R2 - Software keeps reserved bits at reset value
// R3 - Receive end enters init when enabled
// R4 - Zero sequencing field releases RF subsystem control
// R5 - Software writes 0xE7 to hand over control
// R6 - Transmit done enters sleep when enabled
// R7 - Wake clears sleep-after-transmit unless preserved
// R8 - Receive end enters sleep when enabled
// R9 - Wake clears sleep-after-receive unless preserved
// R10 - Automatic sleep needs the sleep enable bit
// R11 - Snooze enable runs crystal-timed low-power period
// R12 - Snooze length comes from snooze period register
// R13 - Snooze repeat cycles snooze and receive forever
// R14 - Edge detect run enable resets to one
// R15 - Upper six bits of kilohertz divider count
// R16 - Pending interrupt blocks automatic transitions; the code blocks only those out of active, not the return at snooze end
`timescale 1ns/1ps
module apsc_top #(
    parameter int SNOOZE_UNIT_TICKS = apsc_pkg::SNZ_UNIT_TICKS
) (
    // Clock and reset
    input  wire logic                aclk,
    input  wire logic                aresetn,
    // AXI4-Lite write address
    input  wire logic                s_axi_awvalid,
    output logic                     s_axi_awready,
    input  wire logic [7:0]          s_axi_awaddr,
    input  wire logic [2:0]          s_axi_awprot,
    // AXI4-Lite write data
    input  wire logic                s_axi_wvalid,
    output logic                     s_axi_wready,
    input  wire logic [31:0]         s_axi_wdata,
    input  wire logic [3:0]          s_axi_wstrb,
    // AXI4-Lite write response
    output logic                     s_axi_bvalid,
    input  wire logic                s_axi_bready,
    output logic [1:0]               s_axi_bresp,
    // AXI4-Lite read address
    input  wire logic                s_axi_arvalid,
    output logic                     s_axi_arready,
    input  wire logic [7:0]          s_axi_araddr,
    input  wire logic [2:0]          s_axi_arprot,
    // AXI4-Lite read data
    output logic                     s_axi_rvalid,
    input  wire logic                s_axi_rready,
    output logic [31:0]              s_axi_rdata,
    output logic [1:0]               s_axi_rresp,
    // Radio events from the same clock domain
    input  wire apsc_pkg::apsc_evt_t evt,
    // Power control outputs
    output apsc_pkg::apsc_ctl_t      ctl,
    output logic                     khz_clk,
    output logic                     khz_tick
);
    apsc_pkg::apsc_top_st_t q;
    apsc_pkg::apsc_top_st_t d;
    logic                   xtal_tick;
    logic                   snz_busy;
    logic                   snz_done;
    logic                   sleep_ok;
    logic                   wr_go;
    logic                   rd_go;
    logic [7:0]             wr_addr;
    logic [31:0]            merged;

    // ==================================================================
    // Helpers
    function automatic logic [31:0] apply_strobe(
        input logic [31:0] old_v,
        input logic [31:0] new_v,
        input logic [3:0]  strb
    );
        logic [31:0] r;
        r = old_v;
        for (int i = 0; i < 4; i++) begin
            if (strb[i]) begin
                r[i*8 +: 8] = new_v[i*8 +: 8];
            end
        end
        return r;
    endfunction : apply_strobe

    function automatic logic is_mapped(input logic [7:0] a);
        logic [7:0] w;
        w = {a[7:2], 2'b00};
        return (w == apsc_pkg::ADDR_CTRL_ONE)   ||
               (w == apsc_pkg::ADDR_SNZ_PERIOD) ||
               (w == apsc_pkg::ADDR_WAKE_CFG)   ||
               (w == apsc_pkg::ADDR_STATUS);
    endfunction : is_mapped

    function automatic logic [31:0] read_word(
        input apsc_pkg::apsc_top_st_t s,
        input logic [7:0]             a,
        input logic                   irq,
        input logic                   khz,
        input logic                   snz
    );
        logic [31:0] r;
        logic [7:0]  w;
        r = 32'h0000_0000;
        w = {a[7:2], 2'b00};
        case (w)
            apsc_pkg::ADDR_CTRL_ONE: begin
                r = s.ctrl;
            end
            apsc_pkg::ADDR_SNZ_PERIOD: begin
                r[7:0] = s.snz_per;
            end
            apsc_pkg::ADDR_WAKE_CFG: begin
                r[2:0] = s.wcfg;
            end
            apsc_pkg::ADDR_STATUS: begin
                r[1:0]                     = s.pstate;
                r[apsc_pkg::STAT_IRQ_BIT]  = irq;
                r[apsc_pkg::STAT_KHZ_BIT]  = khz;
                r[apsc_pkg::STAT_SNZ_BIT]  = snz;
            end
            default: begin
                r = 32'h0000_0000;
            end
        endcase
        return r;
    endfunction : read_word

    // ==================================================================
    // Clock divider and snooze timer
    apsc_xtal_div u_div (
        .aclk      (aclk),
        .aresetn   (aresetn),
        .div_hi    (q.ctrl[apsc_pkg::KHZ_MSB:apsc_pkg::KHZ_LSB]), // R15
        .xtal_tick (xtal_tick),
        .khz_clk   (khz_clk),
        .khz_tick  (khz_tick)
    );

    apsc_snooze_tmr #(
        .UNIT_TICKS (SNOOZE_UNIT_TICKS)
    ) u_snz (
        .aclk    (aclk),
        .aresetn (aresetn),
        .start   (q.snz_start),
        .period  (q.snz_per), // R12
        .tick    (xtal_tick), // R11
        .busy    (snz_busy),
        .done    (snz_done)
    );

    // ==================================================================
    // Bus handshakes
    assign s_axi_awready = !q.aw_have;
    assign s_axi_wready  = !q.w_have;
    assign s_axi_arready = !q.rvalid;
    assign s_axi_bvalid  = q.bvalid;
    assign s_axi_bresp   = q.bresp;
    assign s_axi_rvalid  = q.rvalid;
    assign s_axi_rdata   = q.rdata;
    assign s_axi_rresp   = q.rresp;

    assign wr_go   = q.aw_have && q.w_have && !q.bvalid;
    assign rd_go   = s_axi_arvalid && !q.rvalid;
    assign wr_addr = {q.aw_addr[7:2], 2'b00};

    // Automatic sleep only with the always-on sleep enable
    assign sleep_ok = q.wcfg[apsc_pkg::SLEEP_EN_BIT]; // R10

    // ==================================================================
    // Next state
    always_comb begin
        d           = q;
        d.rx_start  = 1'b0;
        d.snz_start = 1'b0;
        merged      = 32'h0000_0000;

        // Power sequencing first so a same-cycle write wins
        case (q.pstate)
            apsc_pkg::PS_ACTIVE: begin
                if (!evt.irq_pending) begin // R16
                    if (evt.tx_done && sleep_ok &&
                        q.ctrl[apsc_pkg::TX_SLP_BIT]) begin // R6
                        d.pstate = apsc_pkg::PS_SLEEP;
                    end else if (evt.rx_end) begin
                        if (sleep_ok &&
                            q.ctrl[apsc_pkg::RX_SLP_BIT]) begin // R8
                            d.pstate = apsc_pkg::PS_SLEEP;
                        end else if (q.ctrl[apsc_pkg::SNZ_EN_BIT]) begin
                            d.pstate    = apsc_pkg::PS_SNOOZE; // R11 R13
                            d.snz_start = 1'b1;
                        end else if (q.ctrl[apsc_pkg::RX_INIT_BIT]) begin
                            d.pstate = apsc_pkg::PS_INIT; // R3
                        end
                    end
                end
            end
            apsc_pkg::PS_INIT: begin
                if (evt.wake) begin
                    d.pstate = apsc_pkg::PS_ACTIVE;
                end
            end
            apsc_pkg::PS_SLEEP: begin
                if (evt.wake) begin
                    d.pstate = apsc_pkg::PS_ACTIVE;
                    if (!q.wcfg[apsc_pkg::PRESERVE_SLEEP_CONFIG_BIT]) begin
                        d.ctrl[apsc_pkg::TX_SLP_BIT] = 1'b0; // R7
                        d.ctrl[apsc_pkg::RX_SLP_BIT] = 1'b0; // R9
                    end
                end
            end
            apsc_pkg::PS_SNOOZE: begin
                if (snz_done) begin
                    // Snooze over: restart the receiver
                    d.pstate   = apsc_pkg::PS_ACTIVE;
                    d.rx_start = 1'b1;
                    if (!q.ctrl[apsc_pkg::SNZ_RPT_BIT]) begin // R13
                        d.ctrl[apsc_pkg::SNZ_EN_BIT] = 1'b0;
                    end
                end else if (evt.wake && !snz_busy && !q.snz_start) begin
                    d.pstate = apsc_pkg::PS_ACTIVE;
                end
            end
            default: begin
                d.pstate = apsc_pkg::PS_ACTIVE;
            end
        endcase

        // Write address and data taken in either order
        if (s_axi_awvalid && !q.aw_have) begin
            d.aw_have = 1'b1;
            d.aw_addr = s_axi_awaddr;
        end
        if (s_axi_wvalid && !q.w_have) begin
            d.w_have = 1'b1;
            d.w_data = s_axi_wdata;
            d.w_strb = s_axi_wstrb;
        end
        if (q.bvalid && s_axi_bready) begin
            d.bvalid = 1'b0;
        end
        if (wr_go) begin
            d.aw_have = 1'b0;
            d.w_have  = 1'b0;
            d.bvalid  = 1'b1;
            d.bresp   = is_mapped(q.aw_addr) ? apsc_pkg::RESP_OKAY
                                             : apsc_pkg::RESP_SLVERR;
            case (wr_addr)
                apsc_pkg::ADDR_CTRL_ONE: begin
                    merged = apply_strobe(d.ctrl, q.w_data, q.w_strb);
                    // Reserved bits hold their reset value
                    d.ctrl = (merged & apsc_pkg::CTRL_ONE_WMASK) |
                             (apsc_pkg::CTRL_ONE_RESET &
                              ~apsc_pkg::CTRL_ONE_WMASK); // R1
                end
                apsc_pkg::ADDR_SNZ_PERIOD: begin
                    if (q.w_strb[0]) begin
                        d.snz_per = q.w_data[7:0];
                    end
                end
                apsc_pkg::ADDR_WAKE_CFG: begin
                    if (q.w_strb[0]) begin
                        d.wcfg = q.w_data[2:0];
                    end
                end
                default: begin
                    d.wcfg = d.wcfg;
                end
            endcase
        end

        // Read channel
        if (q.rvalid && s_axi_rready) begin
            d.rvalid = 1'b0;
        end
        if (rd_go) begin
            d.rvalid = 1'b1;
            d.rdata  = read_word(q, s_axi_araddr, evt.irq_pending,
                                 khz_clk, snz_busy);
            d.rresp  = is_mapped(s_axi_araddr) ? apsc_pkg::RESP_OKAY
                                               : apsc_pkg::RESP_SLVERR;
        end
    end

    // ==================================================================
    // State register
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            q         <= '0;
            q.ctrl    <= apsc_pkg::CTRL_ONE_RESET; // R14
            q.snz_per <= apsc_pkg::SNZ_PERIOD_RESET;
            q.wcfg    <= apsc_pkg::WAKE_CFG_RESET;
            q.pstate  <= apsc_pkg::PS_ACTIVE;
        end else begin
            q <= d;
        end
    end

    // ==================================================================
    // Power control outputs
    always_comb begin
        ctl             = '0;
        ctl.pstate      = q.pstate;
        ctl.deep_sleep  = (q.pstate == apsc_pkg::PS_SLEEP) &&
                          q.wcfg[apsc_pkg::DEEP_SEL_BIT];
        ctl.rf_seq_mask = q.ctrl[apsc_pkg::RFSEQ_MSB:apsc_pkg::RFSEQ_LSB];
        ctl.rf_seq_en   = (ctl.rf_seq_mask != 8'h00); // R4
        ctl.edge_run_en = q.ctrl[apsc_pkg::EDGE_RUN_BIT]; // R14
        ctl.rx_start    = q.rx_start; // R13
    end

endmodule : apsc_top

/* File: apsc_top_properties.sv */
// Assertion checker for the power state control block
`timescale 1ns/1ps
module apsc_props #(
    parameter int SNOOZE_UNIT_TICKS = 256
) (
    // Clock and reset
    input wire logic                aclk,
    input wire logic                aresetn,
    // Register bus
    input wire logic                s_axi_awvalid,
    input wire logic                s_axi_awready,
    input wire logic                s_axi_wvalid,
    input wire logic                s_axi_wready,
    input wire logic                s_axi_bvalid,
    input wire logic                s_axi_bready,
    input wire logic [1:0]          s_axi_bresp,
    input wire logic                s_axi_arvalid,
    input wire logic                s_axi_arready,
    input wire logic                s_axi_rvalid,
    input wire logic                s_axi_rready,
    input wire logic [31:0]         s_axi_rdata,
    // Events and control
    input wire apsc_pkg::apsc_evt_t evt,
    input wire apsc_pkg::apsc_ctl_t ctl
);
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);

    // ==================================================================
    // Sequences
    sequence s_wr_both;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
            && !s_axi_bvalid;
    endsequence
    sequence s_rd_take;
        s_axi_arvalid && s_axi_arready;
    endsequence

    // ==================================================================
    // Properties
    a_wr_resp_time: assert property (s_wr_both |-> ##2 s_axi_bvalid)
        else $error("write response late");
    a_b_hold: assert property (s_axi_bvalid && !s_axi_bready
        |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped");
    a_rd_resp_time: assert property (s_rd_take |=> s_axi_rvalid)
        else $error("read response late");
    a_r_hold: assert property (s_axi_rvalid && !s_axi_rready
        |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data dropped");
    a_seq_en_decode: assert property (
        ctl.rf_seq_en == (ctl.rf_seq_mask != 8'h00))
        else $error("sequencing enable mismatch");
    a_irq_blocks_auto: assert property (
        ctl.pstate == apsc_pkg::PS_ACTIVE && evt.irq_pending
        |=> ctl.pstate == apsc_pkg::PS_ACTIVE)
        else $error("left active with interrupt pending");
    a_leave_active_cause: assert property (
        $past(ctl.pstate) == apsc_pkg::PS_ACTIVE
        && ctl.pstate != apsc_pkg::PS_ACTIVE
        |-> $past(evt.tx_done || evt.rx_end) && !$past(evt.irq_pending))
        else $error("left active without event");
    a_wake_exit: assert property (
        ($past(ctl.pstate) == apsc_pkg::PS_INIT
        || $past(ctl.pstate) == apsc_pkg::PS_SLEEP)
        && ctl.pstate != $past(ctl.pstate) |-> $past(evt.wake))
        else $error("left sleep without wake");
    a_deep_in_sleep: assert property (
        ctl.deep_sleep |-> ctl.pstate == apsc_pkg::PS_SLEEP)
        else $error("deep sleep outside sleep");
    a_rx_start_snz: assert property ($rose(ctl.rx_start)
        |-> $past(ctl.pstate) == apsc_pkg::PS_SNOOZE
        && ctl.pstate == apsc_pkg::PS_ACTIVE)
        else $error("receive start outside snooze end");
    a_rx_start_pulse: assert property (ctl.rx_start |=> !ctl.rx_start)
        else $error("receive start too long");
endmodule : apsc_props

bind apsc_top apsc_props #(
    .SNOOZE_UNIT_TICKS(SNOOZE_UNIT_TICKS)
) u_props (
    .aclk         (aclk),
    .aresetn      (aresetn),
    .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready),
    .s_axi_wvalid (s_axi_wvalid),
    .s_axi_wready (s_axi_wready),
    .s_axi_bvalid (s_axi_bvalid),
    .s_axi_bready (s_axi_bready),
    .s_axi_bresp  (s_axi_bresp),
    .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready),
    .s_axi_rvalid (s_axi_rvalid),
    .s_axi_rready (s_axi_rready),
    .s_axi_rdata  (s_axi_rdata),
    .evt          (evt),
    .ctl          (ctl)
);

/* File: apsc_tb.sv */
// Self-checking testbench of the power state control block
`timescale 1ns/1ps
module testbench;
    localparam logic [31:0] RST = apsc_pkg::CTRL_ONE_RESET;
    localparam logic [7:0]  CTL = apsc_pkg::ADDR_CTRL_ONE;
    localparam logic [7:0]  WCF = apsc_pkg::ADDR_WAKE_CFG;
    localparam logic [1:0]  OK  = apsc_pkg::RESP_OKAY;
    logic                aclk, aresetn, awv, awr, wv, wrd, bv, br;
    logic                arv, arr, rv, rr, khz_clk, khz_tick;
    logic [7:0]          awa, ara;
    logic [31:0]         wd, rdd;
    logic [1:0]          bresp, rresp;
    apsc_pkg::apsc_evt_t evt;
    apsc_pkg::apsc_ctl_t ctl;
    int                  failures, cmp_count, cyc;

    apsc_top #(.SNOOZE_UNIT_TICKS(1)) dut (
        .aclk(aclk), .aresetn(aresetn),
        .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_awaddr(awa),
        .s_axi_awprot(3'h0), .s_axi_wvalid(wv), .s_axi_wready(wrd),
        .s_axi_wdata(wd), .s_axi_wstrb(4'hF), .s_axi_bvalid(bv),
        .s_axi_bready(br), .s_axi_bresp(bresp), .s_axi_arvalid(arv),
        .s_axi_arready(arr), .s_axi_araddr(ara), .s_axi_arprot(3'h0),
        .s_axi_rvalid(rv), .s_axi_rready(rr), .s_axi_rdata(rdd),
        .s_axi_rresp(rresp), .evt(evt), .ctl(ctl),
        .khz_clk(khz_clk), .khz_tick(khz_tick)
    );

    always #12.5 aclk = ~aclk;

    // ==================================================================
    // Common tasks
    task automatic conclude;
        $display("failures %0d compares %0d", failures, cmp_count);
        if (failures == 0 && cmp_count > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : conclude

    always @(posedge aclk) begin
        cyc <= cyc + 1;
        if (cyc == 10000) begin
            failures++;
            conclude();
        end
    end

    task automatic chk(input logic [31:0] g, e, input string m);
        cmp_count++;
        if (g !== e) begin
            failures++;
            $display("[FAIL] %0t %s got %h exp %h", $time, m, g, e);
        end
    endtask : chk

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge aclk);
        awv <= 1'b1; wv <= 1'b1; awa <= a; wd <= d; br <= 1'b1;
        do begin
            @(posedge aclk);
            if (awr) awv <= 1'b0;
            if (wrd) wv <= 1'b0;
        end while (!bv);
        br <= 1'b0;
        chk(32'(bresp), 32'(OK), "write response");
    endtask : wr

    task automatic rc(input logic [7:0] a, input logic [31:0] e,
                      input logic [1:0] er);
        @(posedge aclk);
        arv <= 1'b1; ara <= a; rr <= 1'b1;
        do begin
            @(posedge aclk);
            if (arr) arv <= 1'b0;
        end while (!rv);
        rr <= 1'b0;
        chk(rdd, e, "read data");
        chk(32'(rresp), 32'(er), "read response");
    endtask : rc

    // Pulse {tx_done, rx_end, wake}, then check the next state
    task automatic ev(input logic [2:0] p, input apsc_pkg::apsc_pstate_t e);
        @(posedge aclk);
        evt[3:1] <= p;
        @(posedge aclk);
        evt[3:1] <= 3'h0;
        @(posedge aclk);
        chk(32'(ctl.pstate), 32'(e), "power state");
    endtask : ev

    // ==================================================================
    // Scenarios
    task automatic t_regs;
        rc(CTL, RST, OK);
        chk(32'(ctl.rf_seq_mask), 32'hE7, "mask");
        chk(32'(ctl.edge_run_en), 32'h1, "edge run");
        rc(8'h08, 32'h0, apsc_pkg::RESP_SLVERR);
        wr(CTL, 32'hFD02_FFFA);
        rc(CTL, 32'hFD02_FFFA, OK);
        wr(CTL, RST & ~32'h0002_07F8);
        chk(32'(ctl.rf_seq_en), 32'h0, "seq enable");
        chk(32'(ctl.edge_run_en), 32'h0, "edge run");
        wr(CTL, RST);
        chk(32'(ctl.rf_seq_en), 32'h1, "seq enable");
    endtask : t_regs

    task automatic t_rxinit;
        wr(CTL, RST | 32'h2);
        @(posedge aclk);
        evt.irq_pending <= 1'b1;
        ev(3'b010, apsc_pkg::PS_ACTIVE);
        evt.irq_pending <= 1'b0;
        ev(3'b010, apsc_pkg::PS_INIT);
        ev(3'b001, apsc_pkg::PS_ACTIVE);
    endtask : t_rxinit

    task automatic t_sleep;
        wr(WCF, 32'h4);
        wr(CTL, RST | 32'h1800);
        ev(3'b100, apsc_pkg::PS_ACTIVE);
        ev(3'b010, apsc_pkg::PS_ACTIVE);
        wr(WCF, 32'h5);
        ev(3'b100, apsc_pkg::PS_SLEEP);
        chk(32'(ctl.deep_sleep), 32'h1, "deep sleep");
        ev(3'b001, apsc_pkg::PS_ACTIVE);
        rc(CTL, RST, OK);
        wr(WCF, 32'h3);
        wr(CTL, RST | 32'h1000);
        ev(3'b010, apsc_pkg::PS_SLEEP);
        chk(32'(ctl.deep_sleep), 32'h0, "deep sleep");
        ev(3'b001, apsc_pkg::PS_ACTIVE);
        rc(CTL, RST | 32'h1000, OK);
        wr(WCF, 32'h0);
    endtask : t_sleep

    task automatic t_snooze(input int p, input logic [31:0] bits);
        int n;
        wr(apsc_pkg::ADDR_SNZ_PERIOD, 32'(p));
        wr(CTL, RST | bits);
        ev(3'b010, apsc_pkg::PS_SNOOZE);
        n = 1;
        while (ctl.pstate !== apsc_pkg::PS_ACTIVE) begin
            @(posedge aclk);
            n++;
        end
        chk(32'(ctl.rx_start), 32'h1, "receive start");
        chk(32'(n >= 2 * p && n <= 3 * p + 6), 32'h1, "snooze time");
        rc(CTL, RST | (bits & 32'h4000 ? bits : 32'h0), OK);
        wr(CTL, RST);
    endtask : t_snooze

    task automatic t_khz;
        int n;
        wr(CTL, (RST & 32'h03FF_FFFF) | 32'h0400_0000);
        do @(posedge aclk); while (!khz_tick);
        chk(32'(khz_clk), 32'h1, "khz level");
        n = 0;
        do begin
            @(posedge aclk);
            n++;
        end while (!khz_tick);
        chk(32'(n >= 65 && n <= 68), 32'h1, "khz period");
        wr(CTL, RST);
    endtask : t_khz

    // ==================================================================
    // Main sequence
    initial begin
        aclk = 1'b0; aresetn = 1'b0; awv = 1'b0; wv = 1'b0; br = 1'b0;
        arv = 1'b0; rr = 1'b0; awa = 8'h00; ara = 8'h00; wd = 32'h0;
        evt = '0; failures = 0; cmp_count = 0; cyc = 0;
        repeat (4) @(posedge aclk);
        aresetn <= 1'b1;
        t_regs();
        t_rxinit();
        t_sleep();
        t_snooze(3, 32'h2000);
        t_snooze(10, 32'h2000);
        t_snooze(2, 32'h6000);
        t_khz();
        conclude();
    end
endmodule : testbench
